// ==== hdl/ces_top.sv ====
// ces_top: exception sequencer of a 32-bit core with AHB-Lite registers
// assumes a word memory port that acks each request once, and a
// decoder that flags each instruction for one cycle
//
// What this block does
// RULE1: priority reset, address error, interrupts, instructions
// RULE2: reset processing starts when reset is released
// RULE3: address error, interrupt wait instruction completion
// RULE4: trap opcode immediate selects the vector
// RULE5: undefined opcode outside slot: general illegal
// RULE6: undefined or pc-writing opcode in slot: slot illegal
// RULE7: reset fetches pc at 0, sp at 4
// RULE8: reset clears vector base, mask to all ones
// RULE9: execution starts at fetched reset pc
// RULE10: push status word and pc onto stack
// RULE11: accepted interrupt level copied into mask
// RULE12: other exceptions leave mask unchanged
// RULE13: fetch handler address from vector entry, jump
// RULE14: vector address is base plus four times number
// RULE15: fixed vector numbers per source
// RULE16: interrupt at or below mask is refused
// RULE17: sequence runs to the end without interruption
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/10ps
module ces_top (
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	// ahb-lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic [31:0]      o_hrdata,
	output logic             o_hresp,
	output logic             o_irq,
	// decoder and pipeline
	input  wire logic        i_dec_valid,
	input  wire logic        i_dec_undef,
	input  wire logic        i_dec_trap,
	input  wire logic        i_dec_pc_write,
	input  wire logic        i_in_slot,
	input  wire logic [7:0]  i_dec_imm,
	input  wire logic        i_insn_done,
	input  wire logic        i_addr_err,
	input  wire logic [31:0] i_cur_pc,
	input  wire logic [31:0] i_stack_gpr,
	// interrupt controller
	input  wire logic        i_nmi,
	input  wire logic        i_irq_req,
	input  wire logic [3:0]  i_irq_level,
	input  wire logic [7:0]  i_irq_vec,
	output logic             o_irq_ack,
	// memory port
	output logic             o_mem_req,
	output logic             o_mem_we,
	output logic [31:0]      o_mem_addr,
	output logic [31:0]      o_mem_wdata,
	input  wire logic        i_mem_ack,
	input  wire logic [31:0] i_mem_rdata,
	// core state
	output logic             o_pc_load,
	output logic [31:0]      o_program_counter,
	output logic             o_sp_load,
	output logic [31:0]      o_stack_pointer,
	output logic [31:0]      o_status_word,
	output logic [31:0]      o_vector_base_reg,
	output logic             o_busy
);

	// vector table address; base is zero for reset vectors
	function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] num);
		vec_addr = base + {22'h0, num, 2'h0}; // RULE14
	endfunction

	ces_pkg::ces_state_t st_r;
	logic [31:0] sp_r;
	logic [31:0] sr_r;
	logic [31:0] vbase_r;
	logic [31:0] ctrl_r;
	logic [31:0] saved_sr_r;
	logic [31:0] saved_pc_r;
	logic [7:0]  vec_r;
	logic [ces_pkg::EV_W-1:0] stat_r;
	logic [ces_pkg::EV_W-1:0] imask_r;
	logic [ces_pkg::EV_W-1:0] ev_r;
	logic        ap_wr_r;
	logic [7:0]  ap_addr_r;

	// source qualification
	wire [3:0] cur_mask = sr_r[ces_pkg::SR_IM_LSB +: 4];
	wire irq_ok  = i_irq_req & ctrl_r[ces_pkg::CTRL_IRQEN] & (i_irq_level > cur_mask); // RULE16
	wire aerr_go = i_addr_err & i_insn_done; // RULE3
	wire int_go  = (i_nmi | irq_ok) & i_insn_done; // RULE3
	wire trap_go = i_dec_valid & i_dec_trap & ~i_in_slot; // RULE4
	wire ill_go  = i_dec_valid & i_dec_undef & ~i_in_slot; // RULE5
	wire slot_go = i_dec_valid & i_in_slot & (i_dec_undef | i_dec_pc_write | i_dec_trap); // RULE6
	wire any_go  = aerr_go | int_go | trap_go | ill_go | slot_go;
	// only sampled while idle, so a running sequence is never cut short
	wire take    = (st_r == ces_pkg::ST_RUN) & any_go; // RULE17

	// fixed priority selection
	wire sel_aerr = aerr_go; // RULE1
	wire sel_int  = ~aerr_go & int_go; // RULE1
	wire sel_trap = ~aerr_go & ~int_go & trap_go; // RULE1
	wire sel_ill  = ~aerr_go & ~int_go & ~trap_go & ill_go; // RULE1
	wire sel_slot = ~aerr_go & ~int_go & ~trap_go & ~ill_go; // RULE1
	wire sel_nmi  = sel_int & i_nmi;
	wire [7:0] take_vec = sel_aerr ? ces_pkg::VEC_AERR : // RULE15
	                      sel_nmi  ? ces_pkg::VEC_NMI :
	                      sel_int  ? i_irq_vec :
	                      sel_trap ? i_dec_imm :
	                      sel_ill  ? ces_pkg::VEC_ILL : ces_pkg::VEC_SLOT;
	wire [3:0] new_mask = sel_nmi ? ces_pkg::NMI_LEVEL : i_irq_level; // RULE11
	wire [ces_pkg::EV_W-1:0] take_ev = {sel_slot, sel_ill, sel_trap, sel_int, sel_aerr, 1'b0};

	// memory request of the current state; stack grows downward
	wire [31:0] sp_m1 = sp_r - ces_pkg::WORD_BYTES;
	wire [31:0] sp_m2 = sp_m1 - ces_pkg::WORD_BYTES;
	wire is_mem_st = (st_r != ces_pkg::ST_RUN);
	wire mem_done  = o_mem_req & i_mem_ack;
	wire [31:0] mem_addr_nxt =
		(st_r == ces_pkg::ST_RPC) ? vec_addr(32'h0, ces_pkg::VEC_RST_PC) : // RULE7
		(st_r == ces_pkg::ST_RSP) ? vec_addr(32'h0, ces_pkg::VEC_RST_SP) : // RULE7
		(st_r == ces_pkg::ST_PSR) ? sp_m1 :
		(st_r == ces_pkg::ST_PPC) ? sp_m2 : vec_addr(vbase_r, vec_r); // RULE13
	wire mem_we_nxt = (st_r == ces_pkg::ST_PSR) | (st_r == ces_pkg::ST_PPC);
	wire [31:0] mem_wdata_nxt = (st_r == ces_pkg::ST_PSR) ? saved_sr_r : saved_pc_r; // RULE10

	// bus decode
	wire ap_valid = i_hsel & i_htrans[1] & i_hready;
	wire dp_wr    = ap_wr_r;
	wire wr_ctrl  = dp_wr & (ap_addr_r == ces_pkg::OFS_CTRL);
	wire wr_vbase = dp_wr & (ap_addr_r == ces_pkg::OFS_VBASE);
	wire wr_sr    = dp_wr & (ap_addr_r == ces_pkg::OFS_SR);
	wire wr_stat  = dp_wr & (ap_addr_r == ces_pkg::OFS_STAT);
	wire wr_imask = dp_wr & (ap_addr_r == ces_pkg::OFS_IMASK);
	wire [7:0] ra = i_haddr[7:0];
	wire [31:0] rd_mux =
		(ra == ces_pkg::OFS_CTRL)  ? ctrl_r :
		(ra == ces_pkg::OFS_VBASE) ? vbase_r :
		(ra == ces_pkg::OFS_SR)    ? sr_r :
		(ra == ces_pkg::OFS_STAT)  ? {26'h0, stat_r} :
		(ra == ces_pkg::OFS_IMASK) ? {26'h0, imask_r} :
		(ra == ces_pkg::OFS_INFO)  ? {18'h0, st_r, vec_r} : 32'h0;

	// interrupt status: a new event wins over a write-one clear
	wire [ces_pkg::EV_W-1:0] stat_nxt =
		(stat_r & ~(wr_stat ? i_hwdata[ces_pkg::EV_W-1:0] : 6'h00)) | ev_r;

	// sequencer; starts with the pc fetch as soon as reset is released
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			st_r              <= ces_pkg::ST_RPC; // RULE2
			o_mem_req         <= 1'b0;
			o_mem_we          <= 1'b0;
			o_mem_addr        <= 32'h0;
			o_mem_wdata       <= 32'h0;
			o_program_counter <= 32'h0;
			sp_r              <= 32'h0;
			sr_r              <= ces_pkg::SR_RESET;
			vbase_r           <= ces_pkg::VBASE_RESET;
			saved_sr_r        <= 32'h0;
			saved_pc_r        <= 32'h0;
			vec_r             <= 8'h00;
			o_pc_load         <= 1'b0;
			o_sp_load         <= 1'b0;
			o_irq_ack         <= 1'b0;
			ev_r              <= 6'h00;
		end
		else
		begin
			o_pc_load <= 1'b0;
			o_sp_load <= 1'b0;
			o_irq_ack <= 1'b0;
			ev_r      <= 6'h00;
			if (wr_vbase)
				vbase_r <= i_hwdata;
			if (wr_sr)
				sr_r <= i_hwdata;
			if (mem_done)
				o_mem_req <= 1'b0;
			else if (is_mem_st)
			begin
				o_mem_req   <= 1'b1;
				o_mem_we    <= mem_we_nxt;
				o_mem_addr  <= mem_addr_nxt;
				o_mem_wdata <= mem_wdata_nxt;
			end
			unique case (st_r)
				ces_pkg::ST_RPC:
					if (mem_done)
					begin
						o_program_counter <= i_mem_rdata; // RULE7
						st_r              <= ces_pkg::ST_RSP;
					end
				ces_pkg::ST_RSP:
					if (mem_done)
					begin
						sp_r                          <= i_mem_rdata; // RULE7
						vbase_r                       <= ces_pkg::VBASE_RESET; // RULE8
						sr_r[ces_pkg::SR_IM_LSB +: 4] <= ces_pkg::IM_RESET; // RULE8
						o_pc_load                     <= 1'b1; // RULE9
						o_sp_load                     <= 1'b1;
						ev_r[ces_pkg::EV_RST]         <= 1'b1;
						st_r                          <= ces_pkg::ST_RUN;
					end
				ces_pkg::ST_RUN:
					if (take)
					begin
						saved_sr_r <= sr_r; // RULE10
						saved_pc_r <= i_cur_pc; // RULE10
						sp_r       <= i_stack_gpr; // RULE10
						vec_r      <= take_vec;
						ev_r       <= take_ev;
						o_irq_ack  <= sel_int;
						// mask left alone unless an interrupt was taken
						if (sel_int)
							sr_r[ces_pkg::SR_IM_LSB +: 4] <= new_mask; // RULE11 RULE12
						st_r <= ces_pkg::ST_PSR;
					end
				ces_pkg::ST_PSR:
					if (mem_done)
						st_r <= ces_pkg::ST_PPC;
				ces_pkg::ST_PPC:
					if (mem_done)
						st_r <= ces_pkg::ST_VEC;
				ces_pkg::ST_VEC:
					if (mem_done)
					begin
						o_program_counter <= i_mem_rdata; // RULE13
						sp_r              <= sp_m2;
						o_pc_load         <= 1'b1;
						o_sp_load         <= 1'b1;
						st_r              <= ces_pkg::ST_RUN;
					end
			endcase
		end
	end

	// software registers and interrupt output
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			ctrl_r  <= ces_pkg::CTRL_RESET;
			stat_r  <= 6'h00;
			imask_r <= 6'h00;
			o_irq   <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= i_hwdata;
			if (wr_imask)
				imask_r <= i_hwdata[ces_pkg::EV_W-1:0];
			stat_r <= stat_nxt;
			o_irq  <= |(stat_nxt & (wr_imask ? i_hwdata[ces_pkg::EV_W-1:0] : imask_r));
		end
	end

	// ahb-lite slave, zero wait states; read data muxed in address phase
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			ap_wr_r     <= 1'b0;
			ap_addr_r   <= 8'h00;
			o_hrdata    <= 32'h0;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end
		else
		begin
			ap_wr_r   <= ap_valid & i_hwrite;
			ap_addr_r <= i_haddr[7:0];
			if (ap_valid & ~i_hwrite)
				o_hrdata <= rd_mux;
		end
	end

	// mirrored core state
	assign o_stack_pointer   = sp_r;
	assign o_status_word     = sr_r;
	assign o_vector_base_reg = vbase_r;
	assign o_busy            = st_r[0];

endmodule

// ==== hdl/ces_pkg.sv ====
// ces_pkg: constants and types of the exception sequencer
// assumes a 32-bit word memory and a 32-bit AHB-Lite register port
package ces_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_VBASE = 8'h04;
	localparam logic [7:0] OFS_SR    = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0C;
	localparam logic [7:0] OFS_IMASK = 8'h10;
	localparam logic [7:0] OFS_INFO  = 8'h14;
	// fields and reset values
	localparam int          SR_IM_LSB   = 4;
	localparam logic [3:0]  IM_RESET    = 4'hF;
	localparam logic [3:0]  NMI_LEVEL   = 4'hF;
	localparam logic [31:0] VBASE_RESET = 32'h0000_0000;
	localparam logic [31:0] SR_RESET    = 32'h0000_00F0;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
	localparam int          CTRL_IRQEN  = 0;
	localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
	// vector numbers
	localparam logic [7:0] VEC_RST_PC = 8'h00;
	localparam logic [7:0] VEC_RST_SP = 8'h01;
	localparam logic [7:0] VEC_ILL    = 8'h04;
	localparam logic [7:0] VEC_SLOT   = 8'h06;
	localparam logic [7:0] VEC_AERR   = 8'h09;
	localparam logic [7:0] VEC_NMI    = 8'h0B;
	// event bits of status and mask registers
	localparam int EV_RST  = 0;
	localparam int EV_AERR = 1;
	localparam int EV_INT  = 2;
	localparam int EV_TRAP = 3;
	localparam int EV_ILL  = 4;
	localparam int EV_SLOT = 5;
	localparam int EV_W    = 6;
	typedef enum logic [5:0] {
		ST_RPC = 6'b000001,
		ST_RSP = 6'b000010,
		ST_RUN = 6'b000100,
		ST_PSR = 6'b001000,
		ST_PPC = 6'b010000,
		ST_VEC = 6'b100000
	} ces_state_t;
endpackage

// ==== dv/ces_mem_model.sv ====
// ces_mem_model: word memory on the sequencer's far side
// assumes req held until ack; i_slow adds three wait cycles
`timescale 1ns/10ps
module ces_mem_model #(
	parameter logic [31:0] PC0 = 32'h0000_0400,
	parameter logic [31:0] SP0 = 32'h0000_3000
) (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_req,
	input  wire logic [31:0] i_addr,
	input  wire logic        i_slow,
	output logic             o_ack,
	output logic [31:0]      o_rdata
);
	logic [1:0] wait_r;
	// handler word is the entry address with bit 31 set, so a wrong vector
	// shows as a wrong pc; data outside ack flips so stale reads get caught
	always_ff @(posedge i_clk)
	begin
		o_ack <= 1'b0;
		o_rdata <= ~o_rdata;
		if (!i_rstn)
		begin
			wait_r <= 2'h0;
			o_rdata <= 32'h5A5A_5A5A;
		end
		else if (i_req && !o_ack && wait_r == (i_slow ? 2'h3 : 2'h0))
		begin
			o_ack <= 1'b1;
			wait_r <= 2'h0;
			o_rdata <= (i_addr == 32'h0) ? PC0 : (i_addr == 32'h4) ? SP0 : 32'h8000_0000 | i_addr;
		end
		else if (i_req && !o_ack)
			wait_r <= wait_r + 2'h1;
	end
endmodule

// ==== dv/ces_top_properties.sv ====
// ces_top_properties: sequence checks on the sequencer ports
// assumes bind onto ces_top; one clock, synchronous active-low reset
`timescale 1ns/10ps
module ces_top_properties (
	input wire logic        i_mclk,
	input wire logic        i_rstn,
	input wire logic        i_nmi,
	input wire logic [3:0]  i_irq_level,
	input wire logic        i_mem_ack,
	input wire logic        o_irq_ack,
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic [31:0] o_mem_addr,
	input wire logic        o_pc_load,
	input wire logic [31:0] o_status_word,
	input wire logic [31:0] o_vector_base_reg
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	// memory handshake: hold until ack, then one idle cycle
	chk_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
		else $error("memory request moved before ack");
	chk_req_gap: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
		else $error("memory request not dropped after ack");
	// reset sequence: pc word at 0 right after release, then sp word at 4
	chk_rst_pc: assert property (!$past(i_rstn, 2) && $past(i_rstn) |-> o_mem_req && !o_mem_we && o_mem_addr == 32'h0)
		else $error("no pc fetch after reset release");
	chk_rst_sp: assert property (o_mem_req && !o_mem_we && o_mem_addr == 32'h0 && i_mem_ack |-> ##2 o_mem_req && o_mem_addr == 32'h4)
		else $error("no sp fetch after pc fetch");
	chk_rst_mask: assert property (!$past(i_rstn) |-> o_status_word[7:4] == 4'hF && o_vector_base_reg == 32'h0)
		else $error("mask or base wrong after reset");
	// a pc load follows the read that just completed: the vector read, or the sp read at reset
	chk_pc_cause: assert property (o_pc_load |-> $past(i_mem_ack) && !$past(o_mem_we))
		else $error("pc load without vector read");
	chk_push_step: assert property ($rose(o_mem_req) && o_mem_we && $past(o_mem_we, 2) |-> o_mem_addr == $past(o_mem_addr, 2) - 32'h4)
		else $error("second push not one word below first");
	chk_irq_level: assert property (o_irq_ack && !$past(i_nmi) |-> $past(i_irq_level) > $past(o_status_word[7:4]))
		else $error("interrupt taken at or below mask");
	cover property (o_irq_ack);
	cover property (o_pc_load && o_status_word[7:4] == 4'h5);
	cover property ($rose(o_mem_req) && o_mem_we);
endmodule
bind ces_top ces_top_properties ces_top_properties_i (.i_mclk(i_mclk), .i_rstn(i_rstn),
	.i_nmi(i_nmi), .i_irq_level(i_irq_level), .i_mem_ack(i_mem_ack), .o_irq_ack(o_irq_ack),
	.o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_pc_load(o_pc_load),
	.o_status_word(o_status_word), .o_vector_base_reg(o_vector_base_reg));

// ==== dv/ces_top_test.sv ====
// ces_top_test: bus tasks and exception runs for the sequencer
// assumes ces_mem_model on the memory port, one 10 MHz clock
`timescale 1ns/10ps
module ces_top_test;
	localparam logic [31:0] PC0 = 32'h0000_0400;
	localparam logic [31:0] SP0 = 32'h0000_3000;
	localparam logic [31:0] GPR = 32'h0000_2000;
	localparam logic [31:0] CPC = 32'h0000_0100;
	localparam logic [31:0] VBASE = 32'h0000_1000;
	logic        clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwr = 1'b0, slow = 1'b0;
	logic        rdy, rq, we, ack, pl, irq, got, spl, busy, hrs;
	logic [1:0]  htr = 2'h0;
	logic [3:0]  lvl = 4'h0;
	logic [7:0]  imm = 8'h0, ivec = 8'h0;
	logic [8:0]  s = 9'h0;
	logic [31:0] ha = 32'h0, hwd = 32'h0;
	logic [31:0] hrd, ma, md, pc, sp, sw, vb, q, wd, stk_sr, stk_pc;
	int          mismatches = 0, n_checks = 0, cyc = 0;

	ces_top ces_top_i (.i_mclk(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(ha),
		.i_htrans(htr), .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(rdy),
		.o_hreadyout(rdy), .o_hrdata(hrd), .o_hresp(hrs), .o_irq(irq), .i_dec_valid(s[0]),
		.i_dec_undef(s[1]), .i_dec_trap(s[2]), .i_dec_pc_write(s[3]), .i_in_slot(s[4]),
		.i_dec_imm(imm), .i_insn_done(s[5]), .i_addr_err(s[6]), .i_cur_pc(CPC),
		.i_stack_gpr(GPR), .i_nmi(s[7]), .i_irq_req(s[8]), .i_irq_level(lvl),
		.i_irq_vec(ivec), .o_irq_ack(), .o_mem_req(rq), .o_mem_we(we), .o_mem_addr(ma),
		.o_mem_wdata(wd), .i_mem_ack(ack), .i_mem_rdata(md), .o_pc_load(pl),
		.o_program_counter(pc), .o_sp_load(spl), .o_stack_pointer(sp), .o_status_word(sw),
		.o_vector_base_reg(vb), .o_busy(busy));
	ces_mem_model #(.PC0(PC0), .SP0(SP0)) ces_mem_model_i (.i_clk(clk), .i_rstn(rstn),
		.i_req(rq), .i_addr(ma), .i_slow(slow), .o_ack(ack), .o_rdata(md));

	always #50 clk = ~clk;

	// stacked words as the memory takes them; the slot address tells which
	always @(posedge clk)
		if (rq && ack && we && ma == GPR - 32'h4)
			stk_sr <= wd;
		else if (rq && ack && we && ma == GPR - 32'h8)
			stk_pc <= wd;

	task automatic cmp(input logic [31:0] got_v, input logic [31:0] exp_v);
		n_checks++;
		if (got_v !== exp_v)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
		end
	endtask

	// one single transfer; read data taken at the data phase's closing edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htr <= 2'b10;
		ha <= {24'h0, a};
		hwr <= w;
		do @(posedge clk); while (rdy !== 1'b1);
		htr <= 2'b00;
		hsel <= 1'b0;
		hwd <= d;
		do @(posedge clk); while (rdy !== 1'b1);
		q = hrd;
	endtask

	// sources pulse for one cycle; pc load awaited under a bound
	task automatic fire(input logic [8:0] f);
		@(posedge clk);
		s <= f;
		@(posedge clk);
		s <= 9'h0;
		got = 1'b0;
		for (int i = 0; i < 60 && !got; i++)
		begin
			@(posedge clk);
			got = (pl === 1'b1) && (spl === 1'b1);
		end
	endtask

	// stack copies cleared first so a missing push cannot pass on old data
	task automatic exc(input logic [8:0] f, input logic [7:0] v, input logic [3:0] m,
		input logic [31:0] ss);
		stk_sr <= 32'h0;
		stk_pc <= 32'h0;
		fire(f);
		cmp({31'h0, got}, 32'h1);
		cmp(pc, 32'h8000_0000 | (VBASE + {22'h0, v, 2'b00}));
		cmp(sp, GPR - 32'h8);
		cmp({28'h0, sw[7:4]}, {28'h0, m});
		cmp(stk_sr, ss);
		cmp(stk_pc, CPC);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			mismatches++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		fire(9'h0);
		cmp(pc, PC0);
		cmp(sp, SP0);
		cmp({28'h0, sw[7:4]}, 32'hF);
		cmp(vb, 32'h0);
		cmp({31'h0, busy}, 32'h0);
		// reset-done status: masked, unmasked, cleared, then an unmapped read
		cmp({31'h0, irq}, 32'h0);
		ahb(1'b1, ces_pkg::OFS_IMASK, 32'h1);
		ahb(1'b0, ces_pkg::OFS_STAT, 32'h0);
		cmp(q, 32'h1);
		cmp({31'h0, irq}, 32'h1);
		ahb(1'b1, ces_pkg::OFS_STAT, 32'h1);
		ahb(1'b0, 8'h1C, 32'h0);
		cmp(q, 32'h0);
		cmp({31'h0, hrs}, 32'h0);
		cmp({31'h0, irq}, 32'h0);
		ahb(1'b1, ces_pkg::OFS_VBASE, VBASE);
		ahb(1'b0, ces_pkg::OFS_VBASE, 32'h0);
		cmp(q, VBASE);
		imm <= 8'h21;
		slow <= 1'b1;
		exc(9'h005, 8'h21, 4'hF, ces_pkg::SR_RESET);
		slow <= 1'b0;
		exc(9'h003, ces_pkg::VEC_ILL, 4'hF, ces_pkg::SR_RESET);
		exc(9'h019, ces_pkg::VEC_SLOT, 4'hF, ces_pkg::SR_RESET);
		exc(9'h013, ces_pkg::VEC_SLOT, 4'hF, ces_pkg::SR_RESET);
		exc(9'h01D, ces_pkg::VEC_SLOT, 4'hF, ces_pkg::SR_RESET);
		fire(9'h040);
		cmp({31'h0, got}, 32'h0);
		exc(9'h165, ces_pkg::VEC_AERR, 4'hF, ces_pkg::SR_RESET);
		lvl <= 4'h5;
		ivec <= 8'h40;
		fire(9'h120);
		cmp({31'h0, got}, 32'h0);
		ahb(1'b1, ces_pkg::OFS_SR, 32'h0000_0030);
		// enable bit off: an interrupt above the mask must still wait
		ahb(1'b1, ces_pkg::OFS_CTRL, 32'h0);
		fire(9'h120);
		cmp({31'h0, got}, 32'h0);
		ahb(1'b1, ces_pkg::OFS_CTRL, 32'h1);
		exc(9'h120, 8'h40, 4'h5, 32'h0000_0030);
		fire(9'h120);
		cmp({31'h0, got}, 32'h0);
		lvl <= 4'h6;
		exc(9'h1A0, ces_pkg::VEC_NMI, 4'hF, 32'h0000_0050);
		// event log of every taken source, last vector, then a mid-run reset
		ahb(1'b0, ces_pkg::OFS_STAT, 32'h0);
		cmp(q, 32'h0000_003E);
		ahb(1'b0, ces_pkg::OFS_INFO, 32'h0);
		cmp(q, 32'h0000_040B);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		fire(9'h0);
		cmp(pc, PC0);
		cmp(vb, 32'h0);
		wrap_up();
	end
endmodule
